// ---- rtl/zero_detect_pkg.sv ----
// Shared constants for the per-channel silence detector, flags and mute.
package zero_detect_pkg;

   // Channel and data widths.
   localparam int          CHANNELS   = 6;       // Output channels.
   localparam int          SAMPLE_W   = 24;      // Audio word width.
   localparam int          LEVEL_W    = 3;       // Modulator level code width.
   localparam int          CNT_W      = 11;      // Run counter width.
   localparam int          EVT_W      = 12;      // Enter plus leave events.

   // Zero run length in sample (word-clock) periods.
   localparam logic [10:0] RUN_LEN    = 11'h400;

   // Level code that stands for the common-mode reference.
   localparam logic [2:0]  COMMON_MODE_LEVEL = 3'h4;

   // Register byte offsets.
   localparam logic [7:0]  CTRL_OFF   = 8'h08;   // Control.
   localparam logic [7:0]  FLAG_OFF   = 8'h0c;   // Live detector state.
   localparam logic [7:0]  IRQ_OFF    = 8'h10;   // Sticky events, W1C.
   localparam logic [7:0]  MASK_OFF   = 8'h14;   // Event mask.

   // Control field positions.
   localparam int          MUTE_EN_BIT  = 0;
   localparam int          INVERT_BIT   = 1;
   localparam int          GPO_EN_BIT   = 2;
   localparam int          GPO_LSB      = 8;
   localparam int          ALL_FLAG_BIT = 6;     // In the flag register.
   localparam int          LEAVE_LSB    = 6;     // In event registers.

   // Reset values and bus encodings.
   localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
   localparam logic [EVT_W-1:0] EVT_RST = 12'h000;
   localparam logic [2:0]  HSIZE_WORD = 3'h2;
   localparam logic        HRESP_OKAY = 1'h0;

endpackage

// ---- rtl/silence_run_detector.sv ----
// One channel's zero-run counter and detected state.
`timescale 1ns/1ps
module silence_run_detector
   import zero_detect_pkg::*;
(
   input  wire logic hclk,           // System clock.
   input  wire logic hresetn,        // Asynchronous reset, active low.
   input  wire logic sample_strobe,  // One pulse per word-clock period.
   input  wire logic sample_zero,    // Current sample is all zero.
   output logic      silent          // Zero-detected state.
);

   ////////////////////////////////////////////////////////////////////////
   // State.

   logic [CNT_W-1:0] run_ff;         // Zero samples seen so far, saturates.
   logic             silent_ff;      // Detected state.
   logic [CNT_W-1:0] nxt_run;        // Next counter value.

   // The counter saturates at the run length so it never wraps back
   // and drops the state during a long silence.
   always_comb
   begin
      nxt_run = run_ff;
      if (!sample_zero)
      begin
         // Any nonzero word restarts the run.
         nxt_run = '0;
      end
      else if (run_ff != RUN_LEN)
      begin
         // Count one more silent period.
         nxt_run = run_ff + CNT_W'(1);
      end
   end

   // Counter update, once per sample period only.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         run_ff <= '0;
      end
      else if (sample_strobe)
      begin
         run_ff <= nxt_run;
      end
   end

   // The state rises on the sample that completes the run and falls
   // on the first nonzero sample, in the same edge.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         silent_ff <= 1'b0;
      end
      else if (sample_strobe)
      begin
         silent_ff <= (nxt_run == RUN_LEN);
      end
   end

   assign silent = silent_ff;

endmodule

// ---- rtl/zero_detect_flag_mute.sv ----
// Six-channel silence detection with flag pins, mute and AHB-Lite registers.
`timescale 1ns/1ps
module zero_detect_flag_mute
   import zero_detect_pkg::*;
(
   input  wire logic                               hclk,
   input  wire logic                               hresetn,
   // AHB-Lite slave.
   input  wire logic                               hsel,
   input  wire logic [31:0]                        haddr,
   input  wire logic [1:0]                         htrans,
   input  wire logic                               hwrite,
   input  wire logic [2:0]                         hsize,
   input  wire logic [31:0]                        hwdata,
   input  wire logic                               hready,
   output logic      [31:0]                        hrdata,
   output logic                                    hreadyout,
   output logic                                    hresp,
   // Sample words, one new set per word-clock period.
   input  wire logic                               sample_strobe,
   input  wire logic [zero_detect_pkg::SAMPLE_W-1:0] serial_input_pair_one_left,
   input  wire logic [zero_detect_pkg::SAMPLE_W-1:0] serial_input_pair_one_right,
   input  wire logic [zero_detect_pkg::SAMPLE_W-1:0] serial_input_pair_two_left,
   input  wire logic [zero_detect_pkg::SAMPLE_W-1:0] serial_input_pair_two_right,
   input  wire logic [zero_detect_pkg::SAMPLE_W-1:0] serial_input_pair_three_left,
   input  wire logic [zero_detect_pkg::SAMPLE_W-1:0] serial_input_pair_three_right,
   // Modulator levels in, output stage sources out.
   input  wire logic [5:0][zero_detect_pkg::LEVEL_W-1:0] modulator_level,
   output logic      [5:0][zero_detect_pkg::LEVEL_W-1:0] analog_channel_output,
   // Flag pins and interrupt.
   output logic      [5:0]                         channel_silent_flag,
   output logic                                    all_channels_silent_flag,
   output logic                                    irq
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Only address bits 7:2 decode, so the set repeats every 256 bytes.
   // True when a word address selects the given register.
   function automatic logic reg_hit(input logic [7:0] addr,
                                    input logic [7:0] off);
      reg_hit = (addr[7:2] == off[7:2]);
   endfunction

   // True when a sample word is all zero.
   function automatic logic is_zero(input logic [SAMPLE_W-1:0] word);
      is_zero = (word == '0);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Declarations.

   logic [31:0]            ctrl_ff;       // Control register.
   logic [EVT_W-1:0]       irq_stat_ff;   // Sticky event bits.
   logic [EVT_W-1:0]       irq_mask_ff;   // Event mask.
   logic [31:0]            hrdata_ff;     // Read data, loaded in address phase.
   logic                   wr_pend_ff;    // Write data phase pending.
   logic [7:0]             wr_addr_ff;    // Latched write address.
   logic [5:0]             silent_prev_ff;// Detector state one cycle ago.
   logic [5:0]             flag_pin_ff;   // Registered flag pins.
   logic                   all_flag_ff;   // Registered combined flag.
   logic [5:0][LEVEL_W-1:0] out_level_ff; // Registered output sources.

   logic [5:0]             chan_zero;     // Per-channel zero sample.
   logic [5:0]             silent;        // Shared detector state.
   logic [5:0]             gated_flag;    // Flags after the invert gate.
   logic [5:0]             mute_sel;      // Channels forced to common mode.
   logic [5:0]             nxt_flag_pin;  // Next flag pin value.
   logic [EVT_W-1:0]       evt;           // Events in this cycle.
   logic [EVT_W-1:0]       w1c;           // Bits written one to clear.
   logic                   addr_phase;    // Valid transfer taken now.
   logic                   mute_en;       // Control: mute enable.
   logic                   invert;        // Control: phase invert.
   logic                   gpo_en;        // Control: general outputs on.
   logic [5:0]             gpo_bits;      // Control: general output bits.

   ////////////////////////////////////////////////////////////////////////
   // Channel mapping.

   // Left and right halves of each input pair become adjacent channels,
   // channel one being bit 0.
   always_comb
   begin
      chan_zero[0] = is_zero(serial_input_pair_one_left);
      chan_zero[1] = is_zero(serial_input_pair_one_right);
      chan_zero[2] = is_zero(serial_input_pair_two_left);
      chan_zero[3] = is_zero(serial_input_pair_two_right);
      chan_zero[4] = is_zero(serial_input_pair_three_left);
      chan_zero[5] = is_zero(serial_input_pair_three_right);
   end

   ////////////////////////////////////////////////////////////////////////
   // Detectors.

   // One independent detector per channel; nothing is shared between
   // channels, so one channel's data never moves another's state.
   // All six share the strobe, so their counts advance together.
   for (genvar ch = 0; ch < CHANNELS; ch++)
   begin : g_det
      silence_run_detector u_det
      (
         .hclk          (hclk),
         .hresetn       (hresetn),
         .sample_strobe (sample_strobe),
         .sample_zero   (chan_zero[ch]),
         .silent        (silent[ch])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Control fields.

   // Fields are pulled out once so every user reads the same bits.
   assign mute_en  = ctrl_ff[MUTE_EN_BIT];
   assign invert   = ctrl_ff[INVERT_BIT];
   assign gpo_en   = ctrl_ff[GPO_EN_BIT];
   assign gpo_bits = ctrl_ff[GPO_LSB +: CHANNELS];

   ////////////////////////////////////////////////////////////////////////
   // Flags and mute.

   // Flag and mute both read the same detector outputs; only mute has an
   // enable of its own (mute_en). Phase inversion blocks both; the detectors keep
   // counting underneath, so the state is already right when the
   // inversion bit is cleared again.
   always_comb
   begin
      gated_flag = invert ? '0 : silent;
      mute_sel   = (mute_en && !invert) ? silent : '0;
   end

   // Pins carry the flags unless software has taken them over.
   always_comb
   begin
      if (gpo_en)
      begin
         nxt_flag_pin = gpo_bits;
      end
      else
      begin
         nxt_flag_pin = gated_flag;
      end
   end

   // Pins are registered, so they trail the detector by one clock.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         flag_pin_ff <= '0;
         all_flag_ff <= 1'b0;
      end
      else
      begin
         flag_pin_ff <= nxt_flag_pin;
         all_flag_ff <= &gated_flag;
      end
   end

   // Reset parks every output at common mode; from the first clock after
   // reset each unmuted output carries its modulator level.
   // Output source select: a muted channel carries the common-mode code
   // in place of the modulator level. The switch is one clock after the
   // detector state changes, in the same clock as the pins.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         out_level_ff <= {CHANNELS{COMMON_MODE_LEVEL}};
      end
      else
      begin
         for (int ch = 0; ch < CHANNELS; ch++)
         begin
            if (mute_sel[ch])
            begin
               out_level_ff[ch] <= COMMON_MODE_LEVEL;
            end
            else
            begin
               out_level_ff[ch] <= modulator_level[ch];
            end
         end
      end
   end

   assign channel_silent_flag      = flag_pin_ff;
   assign all_channels_silent_flag = all_flag_ff;
   assign analog_channel_output    = out_level_ff;

   ////////////////////////////////////////////////////////////////////////
   // Interrupt events.

   // Detector history for edge finding.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         silent_prev_ff <= '0;
      end
      else
      begin
         silent_prev_ff <= silent;
      end
   end

   // Entering silence sets the low six bits, leaving sets the high six.
   // Raw detector state is used so software still sees events while
   // the pins are taken over or the invert bit is set.
   // A channel that enters and leaves silence between two status reads
   // shows both bits, so a short silence is never missed.
   assign evt = {silent_prev_ff & ~silent, silent & ~silent_prev_ff};

   // Write-one-to-clear, only during a write data phase to this register.
   assign w1c = (wr_pend_ff && reg_hit(wr_addr_ff, IRQ_OFF)) ?
                hwdata[EVT_W-1:0] : '0;

   // A new event in the clearing cycle survives: set beats clear.
   // Software that clears and rereads therefore never loses an event.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_stat_ff <= EVT_RST;
      end
      else
      begin
         irq_stat_ff <= (irq_stat_ff & ~w1c) | evt;
      end
   end

   // Level interrupt while any unmasked event bit stands.
   assign irq = |(irq_stat_ff & irq_mask_ff);

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave.

   // Zero wait states and always OKAY; unmapped reads give zero and
   // unmapped or non-word writes are dropped.
   assign hreadyout  = 1'b1;
   assign hresp      = HRESP_OKAY;
   assign addr_phase = hsel && hready && htrans[1];

   // Latch a word write for its data phase. The address is taken every
   // cycle; only wr_pend_ff says whether it belongs to a real write.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= '0;
      end
      else
      begin
         wr_pend_ff <= addr_phase && hwrite && (hsize == HSIZE_WORD);
         wr_addr_ff <= haddr[7:0];
      end
   end

   // Control register.
   // Unused bits are dropped, so they read back as zero.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_ff <= CTRL_RST;
      end
      else if (wr_pend_ff && reg_hit(wr_addr_ff, CTRL_OFF))
      begin
         ctrl_ff <= '0;
         ctrl_ff[MUTE_EN_BIT]        <= hwdata[MUTE_EN_BIT];
         ctrl_ff[INVERT_BIT]         <= hwdata[INVERT_BIT];
         ctrl_ff[GPO_EN_BIT]         <= hwdata[GPO_EN_BIT];
         ctrl_ff[GPO_LSB +: CHANNELS] <= hwdata[GPO_LSB +: CHANNELS];
      end
   end

   // Mask register.
   // A masked event still sets its status bit; it only misses irq.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_mask_ff <= EVT_RST;
      end
      else if (wr_pend_ff && reg_hit(wr_addr_ff, MASK_OFF))
      begin
         irq_mask_ff <= hwdata[EVT_W-1:0];
      end
   end

   // Read data is captured at the address phase so it stands in a flop
   // through the data phase; reads do not clear anything.
   // A status read that races a new event returns the old value; the
   // event is kept and shows on the next read.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata_ff <= '0;
      end
      else if (addr_phase && !hwrite)
      begin
         hrdata_ff <= '0;
         if (reg_hit(haddr[7:0], CTRL_OFF))
         begin
            hrdata_ff <= ctrl_ff;
         end
         else if (reg_hit(haddr[7:0], FLAG_OFF))
         begin
            hrdata_ff[CHANNELS-1:0] <= silent;
            hrdata_ff[ALL_FLAG_BIT] <= &silent;
         end
         else if (reg_hit(haddr[7:0], IRQ_OFF))
         begin
            hrdata_ff[EVT_W-1:0] <= irq_stat_ff;
         end
         else if (reg_hit(haddr[7:0], MASK_OFF))
         begin
            hrdata_ff[EVT_W-1:0] <= irq_mask_ff;
         end
      end
   end

   assign hrdata = hrdata_ff;

endmodule

// ---- verification/zero_detect_props.sv ----
// Port-level checker for the silence detector, bound to its top module.
`timescale 1ns/1ps
module zero_detect_props
   import zero_detect_pkg::*;
(
   input wire logic                                      hclk,
   input wire logic                                      hresetn,
   input wire logic                                      hsel,
   input wire logic [31:0]                               haddr,
   input wire logic [1:0]                                htrans,
   input wire logic                                      hwrite,
   input wire logic [2:0]                                hsize,
   input wire logic [31:0]                               hwdata,
   input wire logic                                      hready,
   input wire logic [31:0]                               hrdata,
   input wire logic                                      hreadyout,
   input wire logic                                      hresp,
   input wire logic                                      sample_strobe,
   input wire logic [zero_detect_pkg::SAMPLE_W-1:0]      serial_input_pair_one_left,
   input wire logic [zero_detect_pkg::SAMPLE_W-1:0]      serial_input_pair_one_right,
   input wire logic [5:0][zero_detect_pkg::LEVEL_W-1:0]  modulator_level,
   input wire logic [5:0][zero_detect_pkg::LEVEL_W-1:0]  analog_channel_output,
   input wire logic [5:0]                                channel_silent_flag,
   input wire logic                                      all_channels_silent_flag
);
   ////////////////////////////////////////////////////////////////////////////
   logic [10:0] zrun_ff;   // Own zero-run count of channel one.
   logic        rd_addr;   // A read address phase is taken.

   assign rd_addr = hsel && htrans[1] && !hwrite && hready;

   // Saturating count, so a late or early flag is judged against our own figure.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         zrun_ff <= 11'h000;
      else if (sample_strobe)
         zrun_ff <= (serial_input_pair_one_left != 24'h000000) ? 11'h000 :
                    (zrun_ff == RUN_LEN) ? RUN_LEN : zrun_ff + 11'h001;
   end

   logic       ctl_wr_ff;  // Control write in its data phase.
   logic [2:0] ctl_ff;     // Own copy of the low control bits.

   // Pins follow invert and general output enable, so keep a copy.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         {ctl_wr_ff, ctl_ff} <= 4'h0;
      else
      begin
         ctl_wr_ff <= hsel && htrans[1] && hwrite && hready && (hsize == HSIZE_WORD)
                      && (haddr[7:2] == CTRL_OFF[7:2]);
         if (ctl_wr_ff)
            ctl_ff <= hwdata[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_okay;
      hreadyout && (hresp == HRESP_OKAY);
   endproperty
   property p_unmapped;
      rd_addr && (haddr[7:0] == 8'h00) |=> hrdata == 32'h0000_0000;
   endproperty
   property p_stands;
      !rd_addr |=> $stable(hrdata);
   endproperty
   property p_all_clear;
      sample_strobe && (serial_input_pair_one_left != 24'h000000) |-> ##2 !all_channels_silent_flag;
   endproperty
   property p_release;
      sample_strobe && (serial_input_pair_one_left != 24'h000000)
      |-> ##2 analog_channel_output[0] == $past(modulator_level[0]);
   endproperty
   property p_not_early;
      $rose(channel_silent_flag[0]) && !$past(ctl_ff[GPO_EN_BIT]) |-> $past(zrun_ff) == RUN_LEN;
   endproperty
   property p_on_time;
      sample_strobe && (serial_input_pair_one_left == 24'h000000) && (zrun_ff == 11'h3ff)
      ##1 !ctl_ff[INVERT_BIT] && !ctl_ff[GPO_EN_BIT] |-> ##1 channel_silent_flag[0];
   endproperty
   property p_flag_clear;
      sample_strobe && (serial_input_pair_one_right != 24'h000000) ##1 !ctl_ff[GPO_EN_BIT]
      |-> ##1 !channel_silent_flag[1];
   endproperty

   a_okay: assert property (p_okay) else $error("bus response not ready and okay");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_stands: assert property (p_stands) else $error("read data moved without a read");
   a_all_clear: assert property (p_all_clear) else $error("combined flag kept after data");
   a_release: assert property (p_release) else $error("mute not released after data");
   a_not_early: assert property (p_not_early) else $error("flag rose before full run");
   a_on_time: assert property (p_on_time) else $error("flag late after full run");
   a_flag_clear: assert property (p_flag_clear) else $error("channel two flag kept");

   c_all: cover property ($rose(all_channels_silent_flag));
   c_mute: cover property (analog_channel_output[0] == COMMON_MODE_LEVEL);
   c_leave: cover property ($fell(channel_silent_flag[0]));
endmodule

bind zero_detect_flag_mute zero_detect_props chk_u (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hsize(hsize), .hwdata(hwdata),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .sample_strobe(sample_strobe), .serial_input_pair_one_left(serial_input_pair_one_left),
   .serial_input_pair_one_right(serial_input_pair_one_right), .modulator_level(modulator_level),
   .analog_channel_output(analog_channel_output), .channel_silent_flag(channel_silent_flag),
   .all_channels_silent_flag(all_channels_silent_flag)
);

// ---- verification/audio_source_model.sv ----
// Behavioural audio source: strobes, sample words and modulator levels.
`timescale 1ns/1ps
module audio_source_model
   import zero_detect_pkg::*;
(
   input  wire logic                                      hclk,
   input  wire logic                                      hresetn,
   input  wire logic                                      run,
   input  wire logic [5:0]                                quiet,
   input  wire logic [zero_detect_pkg::SAMPLE_W-1:0]      noise,
   output logic                                           sample_strobe,
   output logic      [5:0][zero_detect_pkg::SAMPLE_W-1:0] word,
   output logic      [5:0][zero_detect_pkg::LEVEL_W-1:0]  modulator_level
);
   // One strobe per cycle while run is high, the fastest rate allowed.
   assign sample_strobe = run;

   // Quiet channels send zero; outside a strobe the words are inverted,
   // so a detector that samples off the strobe sees garbage.
   always_comb
   begin
      for (int k = 0; k < 6; k++)
      begin
         word[k] = quiet[k] ? 24'h000000 : (noise | 24'h000001);
         if (!run)
            word[k] = ~word[k];
      end
   end

   // Levels step differently per channel, so a swapped source shows up.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         modulator_level <= '0;
      else
         for (int k = 0; k < 6; k++)
            modulator_level[k] <= modulator_level[k] + 3'(k + 1);
   end
endmodule

// ---- verification/zero_detect_flag_mute_tb_top.sv ----
// Self-checking bench for the silence detector, flags, mute and registers.
`timescale 1ns/1ps
module zero_detect_flag_mute_tb_top;
   import zero_detect_pkg::*;
   logic              hclk = 1'b0;
   logic              hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0]       haddr, hwdata, hrdata;
   logic [1:0]        htrans;
   logic [2:0]        hsize;
   logic              run, sample_strobe, all_channels_silent_flag;
   logic              rd_pend = 1'b0;
   logic [5:0]        quiet, channel_silent_flag;
   logic [23:0]       noise = 24'h00005c;
   logic [5:0][23:0]  word;
   logic [5:0][2:0]   modulator_level, analog_channel_output;
   logic [31:0]       exp_q[$];   // Expected read data, oldest first.
   int                errors, tests_run;

   ////////////////////////////////////////////////////////////////////////////
   always #50 hclk = ~hclk;

   audio_source_model src_u (.hclk(hclk), .hresetn(hresetn), .run(run), .quiet(quiet),
      .noise(noise), .sample_strobe(sample_strobe), .word(word), .modulator_level(modulator_level));

   // Pairs carry channels 1-2, 3-4 and 5-6 as left then right.
   zero_detect_flag_mute dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sample_strobe(sample_strobe),
      .serial_input_pair_one_left(word[0]), .serial_input_pair_one_right(word[1]),
      .serial_input_pair_two_left(word[2]), .serial_input_pair_two_right(word[3]),
      .serial_input_pair_three_left(word[4]), .serial_input_pair_three_right(word[5]),
      .modulator_level(modulator_level), .analog_channel_output(analog_channel_output),
      .channel_silent_flag(channel_silent_flag), .all_channels_silent_flag(all_channels_silent_flag),
      .irq(irq));

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [23:0] lfsr(input logic [23:0] s);
      return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One single transfer at the current hsize; entered just after a rising edge.
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h000000, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      ahb(1'b0, a, 32'h0000_0000);
   endtask

   task automatic strobes(input int n);
      run <= 1'b1;
      repeat (n) @(posedge hclk);
      run <= 1'b0;
      repeat (3) @(posedge hclk);
   endtask

   // Pins are registered behind control, so look one clock later, mid-cycle.
   task automatic pins(input logic [5:0] f, input logic a, input logic i);
      @(posedge hclk);
      @(negedge hclk);
      chk({26'h0, channel_silent_flag}, {26'h0, f});
      chk({31'h0, all_channels_silent_flag}, {31'h0, a});
      chk({31'h0, irq}, {31'h0, i});
      @(posedge hclk);
   endtask

   // A muted channel shows common mode, any other last cycle's level.
   task automatic out_chk(input logic [5:0] m);
      logic [5:0][2:0] lv;
      @(negedge hclk);
      lv = modulator_level;
      @(negedge hclk);
      for (int k = 0; k < 6; k++)
         chk({29'h0, analog_channel_output[k]}, {29'h0, m[k] ? COMMON_MODE_LEVEL : lv[k]});
      @(posedge hclk);
   endtask

   task complete_run;
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Read monitor: the edge after a read address phase carries the data.
   always @(posedge hclk)
   begin
      if (rd_pend)
         chk(hrdata, exp_q.pop_front());
      rd_pend <= hresetn && hsel && htrans[1] && !hwrite && hreadyout;
      noise <= lfsr(noise);
   end

   // Cut a hang short; the whole run needs about 2100 cycles.
   initial
   begin
      repeat (20000) @(posedge hclk);
      errors++;
      $display("[FAIL] %0t run did not finish", $time);
      complete_run;
   end

   initial
   begin
      hresetn = 1'b0;
      {hsel, hwrite, run} = 3'h0;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      htrans = 2'h0;
      hsize = HSIZE_WORD;
      quiet = 6'h3f;
      errors = 0;
      tests_run = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      rd(CTRL_OFF, CTRL_RST);
      rd(MASK_OFF, 32'h0000_0000);
      rd(8'h00, 32'h0000_0000);
      ahb(1'b1, CTRL_OFF, 32'h0000_0001);
      ahb(1'b1, MASK_OFF, 32'h0000_0fff);
      quiet <= 6'h3d;
      strobes(1023);
      pins(6'h00, 1'b0, 1'b0);
      strobes(1);
      pins(6'h3d, 1'b0, 1'b1);
      out_chk(6'h3d);
      rd(FLAG_OFF, 32'h0000_003d);
      rd(IRQ_OFF, 32'h0000_003d);
      ahb(1'b1, IRQ_OFF, 32'h0000_003d);
      pins(6'h3d, 1'b0, 1'b0);
      quiet <= 6'h3f;
      strobes(1024);
      pins(6'h3f, 1'b1, 1'b1);
      rd(FLAG_OFF, 32'h0000_007f);
      ahb(1'b1, CTRL_OFF, 32'h0000_0003);
      pins(6'h00, 1'b0, 1'b1);
      out_chk(6'h00);
      ahb(1'b1, CTRL_OFF, 32'h0000_2a05);
      pins(6'h2a, 1'b1, 1'b1);
      rd(CTRL_OFF, 32'h0000_2a05);
      // A byte-sized write must leave control alone.
      hsize <= 3'h0;
      ahb(1'b1, CTRL_OFF, 32'h0000_0000);
      hsize <= HSIZE_WORD;
      rd(CTRL_OFF, 32'h0000_2a05);
      ahb(1'b1, CTRL_OFF, 32'h0000_0001);
      quiet <= 6'h3e;
      strobes(1);
      pins(6'h3e, 1'b0, 1'b1);
      out_chk(6'h3e);
      rd(IRQ_OFF, 32'h0000_0042);
      repeat (2) @(posedge hclk);
      complete_run;
   end
endmodule
